// *** hdl/pmim_map.vh ***
`ifndef PMIM_MAP_VH
`define PMIM_MAP_VH

// register port geometry
`define PMIM_ADDR_W            12
`define PMIM_DATA_W            32

// register offsets, word addressed on the plain port
`define PMIM_OFS_IRQ_MASK      12'h406
`define PMIM_OFS_ALERT_MASK    12'h407
`define PMIM_OFS_IRQ_STATUS    12'h480
`define PMIM_OFS_ALERT_STATUS  12'h481
`define PMIM_OFS_OC_CFG        12'h482
`define PMIM_OFS_SOFT_RST      12'h483

// reset values
`define PMIM_RST_IRQ_MASK      32'h0000_0000
`define PMIM_RST_ALERT_MASK    32'h0000_0000
`define PMIM_RST_OC_CFG        4'h0

// writable bits; every other bit reads zero
`define PMIM_WR_IRQ_MASK       32'h80F6_FFFF
`define PMIM_WR_ALERT_MASK     32'h0001_FE00
`define PMIM_OC_CFG_W          4

// interrupt mask and status bit positions
`define PMIM_B_FAULT3          31
`define PMIM_B_SAG_A           23
`define PMIM_B_SURGE_C         22
`define PMIM_B_SURGE_B         21
`define PMIM_B_SURGE_A         20
`define PMIM_B_ORDER           18
`define PMIM_B_OC              17
`define PMIM_B_ZXI_C           15
`define PMIM_B_ZXI_A           13
`define PMIM_B_COMBINED_VOLTAGE_CROSSING_IRQ_EN          12
`define PMIM_B_ZXV_C           11
`define PMIM_B_ZXV_A           9
`define PMIM_B_ZXTO_C          8
`define PMIM_B_ZXTO_A          6
`define PMIM_B_IDLE_HI         5
`define PMIM_B_IDLE_LO         0

// alert mask and alert status bit positions
`define PMIM_A_WAVEFORM_SAMPLES_READY_EN          16
`define PMIM_A_IDLE_HI         15
`define PMIM_A_IDLE_LO         10
`define PMIM_A_NEG4            9

// soft reset control bit
`define PMIM_B_SOFT_RST        0

`endif

// *** hdl/pmim_sticky.v ***
`timescale 1ns/1ns
`default_nettype none

module pmim_sticky (
    input  wire        clk_in,       // system clock
    input  wire        rst_n_in,     // synchronised reset, active low
    input  wire        ce_in,        // clock enable
    input  wire [31:0] set_in,       // per-bit set pulses
    input  wire [31:0] clr_in,       // per-bit clear pulses
    input  wire        soft_clr_in,  // clears every bit
    output wire [31:0] flags_out     // sticky flags
);

    // one sticky cell per bit, set beats any clear
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            reg flag_r;
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    flag_r <= 1'b0;
                end else if (ce_in) begin
                    flag_r <= set_in[i] | (flag_r & ~clr_in[i] & ~soft_clr_in);
                end
            end
            assign flags_out[i] = flag_r;
        end
    endgenerate

endmodule // pmim_sticky

`default_nettype wire

// *** hdl/pmim_top.v ***
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pmim_map.vh"

module pmim_top (
    input  wire        clk_in,                      // 20 MHz system clock
    input  wire        rst_n_in,                    // async reset, active low
    input  wire        ce_in,                       // clock enable, freezes state when low
    input  wire [11:0] addr_in,                     // register word address
    input  wire [31:0] wdata_in,                    // register write data
    input  wire        wr_in,                       // write strobe
    input  wire        rd_in,                       // read strobe
    output wire [31:0] rdata_out,                   // read data, cycle after rd_in
    input  wire        phase_a_sag_in,              // pulse: phase A enters sag
    input  wire [2:0]  surge_in,                    // pulses: surge entry, [2]=C .. [0]=A
    input  wire        phase_order_fault_in,        // pulse: phase sequence error
    input  wire [3:0]  overcurrent_in,              // pulses: overcurrent, [3]=N .. [0]=A
    input  wire [2:0]  current_crossing_in,         // pulses: current crossing, [2]=C
    input  wire        combined_crossing_in,        // pulse: combined voltage crossing
    input  wire [2:0]  voltage_crossing_in,         // pulses: voltage crossing, [2]=C
    input  wire [2:0]  crossing_timeout_in,         // pulses: missing crossing, [2]=C
    input  wire [5:0]  idle_state_in,               // levels: category idle, order as mask
    input  wire        samples_ready_in,            // pulse: new waveform samples
    input  wire        fault_three_in,              // pulse: fault three occurred
    input  wire        energy_pulse_out_four_in,    // level: pulse output four
    input  wire        pulse4_negative_in,          // level: current pulse four sign negative
    output wire        irq_out,                     // interrupt, active high level
    output wire        alert_n_out                  // alert pin, active low level
);

    // reset release through two flops
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    assign rst_n = rst_s2_r;

    // software visible state
    reg  [31:0] irq_mask_r;
    reg  [31:0] alert_mask_r;
    reg  [3:0]  overcurrent_channel_enables_r;
    reg  [31:0] rdata_r;
    reg         irq_r;
    reg         alert_n_r;
    reg  [5:0]  idle_prev_r;
    reg         pulse4_prev_r;
    reg         neg4_flag_r;
    reg         soft_clr_r;

    wire [31:0] irq_status;
    wire [31:0] alert_sticky;
    wire [31:0] irq_set;
    wire [31:0] irq_clr;
    wire [31:0] alert_set;
    wire [31:0] alert_clr;
    wire [31:0] alert_src;
    wire [5:0]  idle_change;
    wire        oc_hit;
    wire        pulse4_fall;
    wire        wr_irq_mask;
    wire        wr_alert_mask;
    wire        wr_irq_status;
    wire        wr_alert_status;
    wire        wr_oc_cfg;
    wire        wr_soft_rst;

    // write decode
    assign wr_irq_mask     = wr_in && (addr_in == `PMIM_OFS_IRQ_MASK);
    assign wr_alert_mask   = wr_in && (addr_in == `PMIM_OFS_ALERT_MASK);
    assign wr_irq_status   = wr_in && (addr_in == `PMIM_OFS_IRQ_STATUS);
    assign wr_alert_status = wr_in && (addr_in == `PMIM_OFS_ALERT_STATUS);
    assign wr_oc_cfg       = wr_in && (addr_in == `PMIM_OFS_OC_CFG);
    assign wr_soft_rst     = wr_in && (addr_in == `PMIM_OFS_SOFT_RST);

    // mask and config registers, reserved bits forced to zero
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_r                    <= `PMIM_RST_IRQ_MASK;
            alert_mask_r                  <= `PMIM_RST_ALERT_MASK;
            overcurrent_channel_enables_r <= `PMIM_RST_OC_CFG;
        end else if (ce_in) begin
            if (wr_irq_mask) begin
                irq_mask_r <= wdata_in & `PMIM_WR_IRQ_MASK;
            end
            if (wr_alert_mask) begin
                alert_mask_r <= wdata_in & `PMIM_WR_ALERT_MASK;
            end
            if (wr_oc_cfg) begin
                overcurrent_channel_enables_r <= wdata_in[3:0];
            end
        end
    end

    // soft reset pulse, one cycle after the write
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            soft_clr_r <= 1'b0;
        end else if (ce_in) begin
            soft_clr_r <= wr_soft_rst && wdata_in[`PMIM_B_SOFT_RST];
        end
    end

    // history for idle change and pulse four fall detection
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            idle_prev_r   <= 6'h00;
            pulse4_prev_r <= 1'b0;
        end else if (ce_in) begin
            idle_prev_r   <= idle_state_in;
            pulse4_prev_r <= energy_pulse_out_four_in;
        end
    end

    assign idle_change = idle_state_in ^ idle_prev_r;
    assign pulse4_fall = pulse4_prev_r & ~energy_pulse_out_four_in;

    // sign of the last pulse four, taken as the pulse falls
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            neg4_flag_r <= 1'b0;
        end else if (ce_in) begin
            if (pulse4_fall) begin
                neg4_flag_r <= pulse4_negative_in;
            end
        end
    end

    // overcurrent counts only on enabled channels
    assign oc_hit = |(overcurrent_in & overcurrent_channel_enables_r);

    // interrupt event set vector
    assign irq_set[`PMIM_B_FAULT3]   = fault_three_in;
    assign irq_set[30:24]            = 7'h00;
    assign irq_set[`PMIM_B_SAG_A]    = phase_a_sag_in;
    assign irq_set[`PMIM_B_SURGE_C]  = surge_in[2];
    assign irq_set[`PMIM_B_SURGE_B]  = surge_in[1];
    assign irq_set[`PMIM_B_SURGE_A]  = surge_in[0];
    assign irq_set[19]               = 1'b0;
    assign irq_set[`PMIM_B_ORDER]    = phase_order_fault_in;
    assign irq_set[`PMIM_B_OC]       = oc_hit;
    assign irq_set[16]               = 1'b0;
    assign irq_set[`PMIM_B_ZXI_C:`PMIM_B_ZXI_A]   = current_crossing_in;
    assign irq_set[`PMIM_B_COMBINED_VOLTAGE_CROSSING_IRQ_EN]                = combined_crossing_in;
    assign irq_set[`PMIM_B_ZXV_C:`PMIM_B_ZXV_A]   = voltage_crossing_in;
    assign irq_set[`PMIM_B_ZXTO_C:`PMIM_B_ZXTO_A] = crossing_timeout_in;
    assign irq_set[`PMIM_B_IDLE_HI:`PMIM_B_IDLE_LO] = idle_change;

    // write one to clear; fault three ignores it and waits for a reset
    assign irq_clr = wr_irq_status ? (wdata_in & ~(32'h0000_0001 << `PMIM_B_FAULT3))
                                   : 32'h0000_0000;

    pmim_sticky u_irq_status (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .ce_in       (ce_in),
        .set_in      (irq_set),
        .clr_in      (irq_clr),
        .soft_clr_in (soft_clr_r),
        .flags_out   (irq_status)
    );

    // sticky samples ready flag for the alert path
    assign alert_set = {15'h0000, samples_ready_in, 16'h0000};
    assign alert_clr = wr_alert_status ? wdata_in : 32'h0000_0000;

    pmim_sticky u_alert_status (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .ce_in       (ce_in),
        .set_in      (alert_set),
        .clr_in      (alert_clr),
        .soft_clr_in (soft_clr_r),
        .flags_out   (alert_sticky)
    );

    // alert sources, same layout as the alert mask
    assign alert_src[31:17]            = 15'h0000;
    assign alert_src[`PMIM_A_WAVEFORM_SAMPLES_READY_EN]   = alert_sticky[`PMIM_A_WAVEFORM_SAMPLES_READY_EN];
    assign alert_src[`PMIM_A_IDLE_HI:`PMIM_A_IDLE_LO] = idle_state_in;
    assign alert_src[`PMIM_A_NEG4]     = neg4_flag_r;
    assign alert_src[8:0]              = 9'h000;

    // output flops: interrupt and alert follow separate masks
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_r     <= 1'b0;
            alert_n_r <= 1'b1;
        end else if (ce_in) begin
            irq_r     <= |(irq_status & irq_mask_r);
            alert_n_r <= ~|(alert_src & alert_mask_r);
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            if (rd_in) begin
                case (addr_in)
                    `PMIM_OFS_IRQ_MASK:     rdata_r <= irq_mask_r;
                    `PMIM_OFS_ALERT_MASK:   rdata_r <= alert_mask_r;
                    `PMIM_OFS_IRQ_STATUS:   rdata_r <= irq_status;
                    `PMIM_OFS_ALERT_STATUS: rdata_r <= alert_src;
                    `PMIM_OFS_OC_CFG:       rdata_r <= {28'h000_0000, overcurrent_channel_enables_r};
                    default:                rdata_r <= 32'h0000_0000;
                endcase
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    assign rdata_out   = rdata_r;
    assign irq_out     = irq_r;
    assign alert_n_out = alert_n_r;

endmodule // pmim_top

`default_nettype wire

// *** dv/pmim_top_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pmim_map.vh"

module pmim_sva (
    input wire logic        clk_in,      // system clock
    input wire logic        rst_n_in,    // reset, active low
    input wire logic        ce_in,       // clock enable
    input wire logic [11:0] addr_in,     // register address
    input wire logic [31:0] wdata_in,    // write data
    input wire logic        wr_in,       // write strobe
    input wire logic        rd_in,       // read strobe
    input wire logic [31:0] rdata_out,   // read data
    input wire logic        irq_out,     // interrupt
    input wire logic        alert_n_out  // alert pin
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // read data only in the cycle after a read
    rd_idle_zero_a: assert property ($past(ce_in) && !$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    // unmapped places read zero
    unmapped_zero_a: assert property ($past(rd_in && ce_in && addr_in != 12'h406
        && addr_in != 12'h407 && (addr_in < 12'h480 || addr_in > 12'h483))
        |-> rdata_out == 32'h0) else $error("unmapped read not zero");
    status_rsv_a: assert property ($past(rd_in && ce_in
        && addr_in == `PMIM_OFS_IRQ_STATUS) |-> (rdata_out & ~`PMIM_WR_IRQ_MASK) == 32'h0)
        else $error("reserved status bit set");
    alert_rsv_a: assert property ($past(rd_in && ce_in
        && addr_in == `PMIM_OFS_ALERT_STATUS) |-> (rdata_out & ~`PMIM_WR_ALERT_MASK) == 32'h0)
        else $error("reserved alert status bit set");
    // interrupt only drops after a write
    irq_fall_cause_a: assert property ($fell(irq_out) && $past(ce_in)
        |-> $past(wr_in, 2) || $past(wr_in, 3))
        else $error("interrupt dropped without a write");
    irq_mask_rw_a: assert property (wr_in && ce_in && addr_in == `PMIM_OFS_IRQ_MASK
        ##1 !wr_in && ce_in ##1 rd_in && ce_in && addr_in == `PMIM_OFS_IRQ_MASK
        |=> rdata_out == ($past(wdata_in, 3) & `PMIM_WR_IRQ_MASK))
        else $error("interrupt mask readback wrong");
    alert_mask_rw_a: assert property (wr_in && ce_in && addr_in == `PMIM_OFS_ALERT_MASK
        ##1 !wr_in && ce_in ##1 rd_in && ce_in && addr_in == `PMIM_OFS_ALERT_MASK
        |=> rdata_out == ($past(wdata_in, 3) & `PMIM_WR_ALERT_MASK))
        else $error("alert mask readback wrong");
    // a zero interrupt mask keeps the interrupt low
    zero_mask_quiet_a: assert property ($past(rd_in && ce_in && !wr_in
        && addr_in == `PMIM_OFS_IRQ_MASK) && rdata_out == 32'h0 |-> !irq_out)
        else $error("interrupt high with zero mask");

    // main scenarios
    irq_rise_c: cover property ($rose(irq_out));
    alert_low_c: cover property ($fell(alert_n_out));
    status_read_c: cover property ($past(rd_in && addr_in == `PMIM_OFS_IRQ_STATUS)
        && rdata_out != 32'h0);
endmodule // pmim_sva

bind pmim_top pmim_sva u_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .alert_n_out(alert_n_out));
`default_nettype wire

// *** dv/pmim_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module pmim_host (
    input  wire logic       clk_in,        // system clock
    input  wire logic       irq_in,        // interrupt from the block
    input  wire logic       alert_n_in,    // alert pin, active low
    output var  logic [7:0] irq_seen_out,  // interrupt rises serviced
    output var  logic [7:0] alert_seen_out // alert falls serviced
);
    logic       irq_q = 1'b0;
    logic       alt_q = 1'b1;
    logic [7:0] irq_cnt = 8'h00;
    logic [7:0] alt_cnt = 8'h00;
    assign irq_seen_out = irq_cnt;
    assign alert_seen_out = alt_cnt;
    // host notices edges on both lines
    always @(posedge clk_in) begin
        irq_q <= irq_in;
        alt_q <= alert_n_in;
        if (irq_in && !irq_q) irq_cnt <= irq_cnt + 8'h01;
        if (!alert_n_in && alt_q) alt_cnt <= alt_cnt + 8'h01;
    end
endmodule // pmim_host
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pmim_map.vh"

module tb;
    localparam logic [31:0] EVB = 32'h00F6_FFC0;
    logic        clk_in = 0;
    logic        rst_n_in = 0;
    logic        ce_in = 1;
    logic [11:0] addr_in = '0;
    logic [31:0] wdata_in = '0;
    logic        wr_in = 0;
    logic        rd_in = 0;
    logic [31:0] ev = '0;
    logic [3:0]  oc_in = '0;
    logic [5:0]  idle_in = '0;
    logic        rdy_in = 0;
    logic        p4_in = 0;
    logic        neg_in = 0;
    logic [31:0] seed = 32'h8ca1;
    logic [31:0] m;
    logic [31:0] e;
    wire  [31:0] rdata_out;
    wire         irq_out;
    wire         alert_n_out;
    wire  [7:0]  irq_seen;
    wire  [7:0]  alert_seen;
    int          failures = 0;
    int          compares = 0;

    pmim_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .phase_a_sag_in(ev[23]), .surge_in(ev[22:20]), .phase_order_fault_in(ev[18]),
        .overcurrent_in(oc_in), .current_crossing_in(ev[15:13]),
        .combined_crossing_in(ev[12]), .voltage_crossing_in(ev[11:9]),
        .crossing_timeout_in(ev[8:6]), .idle_state_in(idle_in), .samples_ready_in(rdy_in),
        .fault_three_in(ev[31]), .energy_pulse_out_four_in(p4_in),
        .pulse4_negative_in(neg_in), .irq_out(irq_out), .alert_n_out(alert_n_out));
    pmim_host host (.clk_in(clk_in), .irq_in(irq_out), .alert_n_in(alert_n_out),
        .irq_seen_out(irq_seen), .alert_seen_out(alert_seen));

    initial forever #25 clk_in = ~clk_in;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // interrupt level expected from pending flags and mask
    function automatic logic [31:0] exp_irq(input logic [31:0] st, input logic [31:0] mk);
        return {31'h0, |(st & mk & `PMIM_WR_IRQ_MASK)};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_in <= 1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 0;
        #1 chk(rdata_out, exp);
    endtask
    // one-cycle event pulse; bit 17 fans out to every overcurrent channel
    task automatic pulse(input logic [31:0] x, input logic [3:0] o);
        @(posedge clk_in);
        ev <= x;
        oc_in <= o | {4{x[17]}};
        @(posedge clk_in);
        ev <= '0;
        oc_in <= '0;
    endtask
    task automatic end_sim();
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        cyc(20000);
        failures++;
        end_sim();
    end

    initial begin
        cyc(16);
        rst_n_in <= 1;
        cyc(3);
        rd(`PMIM_OFS_IRQ_MASK, 32'h0);
        rd(`PMIM_OFS_ALERT_MASK, 32'h0);
        wr(`PMIM_OFS_IRQ_MASK, '1);
        rd(`PMIM_OFS_IRQ_MASK, `PMIM_WR_IRQ_MASK);
        wr(`PMIM_OFS_ALERT_MASK, '1);
        rd(`PMIM_OFS_ALERT_MASK, `PMIM_WR_ALERT_MASK);
        rd(12'h123, 32'h0);
        wr(`PMIM_OFS_OC_CFG, 32'hF);
        // random events under random masks
        for (int i = 0; i < 40; i++) begin
            m = rnd();
            e = rnd() & EVB;
            wr(`PMIM_OFS_IRQ_MASK, m);
            pulse(e, 4'h0);
            rd(`PMIM_OFS_IRQ_STATUS, e);
            chk({31'h0, irq_out}, exp_irq(e, m));
            wr(`PMIM_OFS_IRQ_STATUS, '1);
        end
        // only enabled overcurrent channels count
        wr(`PMIM_OFS_OC_CFG, 32'h4);
        rd(`PMIM_OFS_OC_CFG, 32'h4);
        pulse(0, 4'hB);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h0);
        pulse(0, 4'h4);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h0002_0000);
        wr(`PMIM_OFS_IRQ_STATUS, '1);
        // fault three survives clearing, only soft reset removes it
        wr(`PMIM_OFS_IRQ_MASK, 32'h8000_0000);
        pulse(32'h8000_0000, 4'h0);
        wr(`PMIM_OFS_IRQ_STATUS, '1);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h8000_0000);
        chk({31'h0, irq_out}, 32'h1);
        wr(`PMIM_OFS_SOFT_RST, 32'h1);
        cyc(2);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        // idle entry and exit
        wr(`PMIM_OFS_IRQ_MASK, 32'h3F);
        @(posedge clk_in);
        idle_in <= 6'h21;
        cyc(2);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h21);
        rd(`PMIM_OFS_ALERT_STATUS, 32'h8400);
        chk({31'h0, alert_n_out}, 32'h0);
        wr(`PMIM_OFS_IRQ_STATUS, '1);
        idle_in <= 6'h00;
        cyc(2);
        rd(`PMIM_OFS_IRQ_STATUS, 32'h21);
        chk({31'h0, alert_n_out}, 32'h1);
        // waveform ready, sticky until cleared
        @(posedge clk_in);
        rdy_in <= 1;
        @(posedge clk_in);
        rdy_in <= 0;
        rd(`PMIM_OFS_ALERT_STATUS, 32'h0001_0000);
        chk({31'h0, alert_n_out}, 32'h0);
        wr(`PMIM_OFS_ALERT_STATUS, 32'h0001_0000);
        rd(`PMIM_OFS_ALERT_STATUS, 32'h0);
        // negative sign taken only on the pulse fall
        @(posedge clk_in);
        neg_in <= 1;
        p4_in <= 1;
        cyc(2);
        rd(`PMIM_OFS_ALERT_STATUS, 32'h0);
        @(posedge clk_in);
        p4_in <= 0;
        cyc(2);
        rd(`PMIM_OFS_ALERT_STATUS, 32'h0200);
        chk({31'h0, alert_n_out}, 32'h0);
        wr(`PMIM_OFS_ALERT_MASK, 32'h0);
        cyc(2);
        chk({31'h0, alert_n_out}, 32'h1);
        chk({31'h0, irq_seen != 8'h0 && alert_seen != 8'h0}, 32'h1);
        // clock enable low: an event and a mask write are both lost
        wr(`PMIM_OFS_IRQ_MASK, 32'h0080_0000);
        wr(`PMIM_OFS_IRQ_STATUS, '1);
        @(posedge clk_in);
        ce_in <= 0;
        ev <= 32'h0080_0000;
        @(posedge clk_in);
        ev <= '0;
        wr(`PMIM_OFS_IRQ_MASK, 32'h0);
        @(posedge clk_in);
        ce_in <= 1;
        rd(`PMIM_OFS_IRQ_STATUS, 32'h0);
        rd(`PMIM_OFS_IRQ_MASK, 32'h0080_0000);
        chk({31'h0, irq_out}, 32'h0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
